// *** rtl/divshift_pkg.sv ***
// shared widths, counts and state codes for the divide and shift block
package divshift_pkg;

  // ---------------------------------------------------------------------
  // word geometry
  // ---------------------------------------------------------------------
  localparam int WORD_W = 16;              // operand word width
  localparam int DVD_W  = 2 * WORD_W;      // double-length dividend
  localparam int REM_W  = WORD_W + 1;      // partial remainder with guard sign
  localparam int CNT_W  = 5;               // step counter width

  // ---------------------------------------------------------------------
  // step counting and special values
  // ---------------------------------------------------------------------
  localparam logic [CNT_W-1:0]  STEP_COUNT = 5'h10;   // one step per bit
  localparam logic [CNT_W-1:0]  STEP_LAST  = 5'h01;
  localparam logic [CNT_W-1:0]  CNT_RESET  = 5'h00;
  localparam logic [WORD_W-1:0] WORD_ZERO  = 16'h0000;
  localparam logic [WORD_W-1:0] Q_NEG_MAX  = 16'h8000; // largest |negative q|
  localparam logic [REM_W-1:0]  REM_ZERO   = 17'h00000;
  localparam logic [DVD_W-1:0]  DVD_ZERO   = 32'h00000000;
  localparam logic              FILL_LEFT  = 1'b0;     // vacated lsb value
  localparam int                SIGN_BIT   = WORD_W - 1;

  // ---------------------------------------------------------------------
  // divide sequencer states
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PREP  = 3'b001,
    ST_CHECK = 3'b010,
    ST_STEP  = 3'b011,
    ST_FIX   = 3'b100
  } div_state_t;

endpackage

// *** rtl/shift_one.sv ***
// single-position shift primitive used by every arithmetic sequence
`timescale 1ns/10ps
module shift_one
#(
  parameter int WIDTH = 16
)
(
  // operand
  input  wire logic [WIDTH-1:0] data_i,
  input  wire logic             left_i,
  input  wire logic             fill_i,
  // result
  output      logic [WIDTH-1:0] data_o,
  output      logic             lost_o
);
  import divshift_pkg::*;

  // ---------------------------------------------------------------------
  // one place only; bit 0 is the rightmost, lowest position
  // ---------------------------------------------------------------------
  always_comb
  begin
    if (left_i)
    begin
      data_o = {data_i[WIDTH-2:0], FILL_LEFT};
      lost_o = data_i[WIDTH-1];
    end
    else
    begin
      data_o = {fill_i, data_i[WIDTH-1:1]};
      lost_o = data_i[0];
    end
  end

endmodule // shift_one

// *** rtl/add_sub.sv ***
// two's complement adder/subtractor shared by the divide steps
`timescale 1ns/10ps
module add_sub
#(
  parameter int WIDTH = 17
)
(
  // operands
  input  wire logic [WIDTH-1:0] a_i,
  input  wire logic [WIDTH-1:0] b_i,
  input  wire logic             sub_i,
  // result
  output      logic [WIDTH-1:0] y_o
);

  // ---------------------------------------------------------------------
  // subtraction is addition of the inverted operand plus one in the lsb
  // ---------------------------------------------------------------------
  always_comb
  begin
    y_o = a_i + (sub_i ? ~b_i : b_i) + {{(WIDTH-1){1'b0}}, sub_i};
  end

endmodule // add_sub

// *** rtl/divshift.sv ***
// non-restoring signed divider and single-position shifter
`timescale 1ns/10ps
module divshift
(
  // clock and reset
  input  wire logic                               clk_i,
  input  wire logic                               rst_n_i,
  // divide request
  input  wire logic                               div_start_i,
  input  wire logic [divshift_pkg::DVD_W-1:0]     dividend_i,
  input  wire logic [divshift_pkg::WORD_W-1:0]    divisor_i,
  // divide result
  output      logic                               div_busy_o,
  output      logic                               div_done_o,
  output      logic [divshift_pkg::WORD_W-1:0]    quotient_o,
  output      logic [divshift_pkg::WORD_W-1:0]    remainder_o,
  output      logic                               overflow_o,
  output      logic                               div_zero_o,
  // shift request
  input  wire logic                               shift_start_i,
  input  wire logic                               shift_left_i,
  input  wire logic                               shift_fill_i,
  input  wire logic [divshift_pkg::WORD_W-1:0]    shift_word_i,
  // shift result
  output      logic                               shift_done_o,
  output      logic [divshift_pkg::WORD_W-1:0]    shift_word_o,
  output      logic                               shift_lost_o
);
  import divshift_pkg::*;

  // ---------------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------------
  div_state_t        state;
  div_state_t        next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [DVD_W-1:0]  dvd;           // dividend, later its magnitude
  logic [DVD_W-1:0]  next_dvd;
  logic              dvd_neg;       // original dividend sign
  logic              next_dvd_neg;
  logic [REM_W-1:0]  dvs;           // sign-extended divisor
  logic [REM_W-1:0]  next_dvs;
  logic [REM_W-1:0]  dvs_mag;       // divisor magnitude
  logic [REM_W-1:0]  next_dvs_mag;
  logic [REM_W-1:0]  rem_r;         // partial remainder
  logic [REM_W-1:0]  next_rem_r;
  logic [WORD_W-1:0] lo;            // low dividend out, quotient in
  logic [WORD_W-1:0] next_lo;

  // ---------------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------------
  logic              next_div_busy;
  logic              next_div_done;
  logic [WORD_W-1:0] next_quotient;
  logic [WORD_W-1:0] next_remainder;
  logic              next_overflow;
  logic              next_div_zero;
  logic              next_shift_done;
  logic [WORD_W-1:0] next_shift_word;
  logic              next_shift_lost;

  // ---------------------------------------------------------------------
  // datapath helpers
  // ---------------------------------------------------------------------
  logic [REM_W+WORD_W-1:0] pair_sh;  // {rem, lo} after one left shift
  logic [REM_W-1:0]        as_a;
  logic [REM_W-1:0]        as_b;
  logic                    as_sub;
  logic [REM_W-1:0]        as_y;
  logic [WORD_W-1:0]       usr_sh;
  logic                    usr_lost;
  logic                    do_sub;
  logic                    q_bit;
  logic [WORD_W-1:0]       q_mag;
  logic [REM_W-1:0]        r_mag;
  logic                    q_neg;

  // the divide step walks remainder and dividend left as one register
  shift_one #(.WIDTH(REM_W + WORD_W)) u_step_shift
  (
    .data_i (({rem_r, lo})),
    .left_i (1'b1),
    .fill_i (FILL_LEFT),
    .data_o (pair_sh),
    .lost_o ()
  );

  // the same primitive serves the user shift request
  shift_one #(.WIDTH(WORD_W)) u_user_shift
  (
    .data_i (shift_word_i),
    .left_i (shift_left_i),
    .fill_i (shift_fill_i),
    .data_o (usr_sh),
    .lost_o (usr_lost)
  );

  // one adder shared by stepping and final correction
  add_sub #(.WIDTH(REM_W)) u_add_sub
  (
    .a_i   (as_a),
    .b_i   (as_b),
    .sub_i (as_sub),
    .y_o   (as_y)
  );

  // ---------------------------------------------------------------------
  // step decisions, meaningful in ST_STEP and ST_FIX
  // ---------------------------------------------------------------------
  always_comb
  begin
    do_sub = (rem_r[REM_W-1] == dvs[REM_W-1]);
    as_a   = pair_sh[REM_W+WORD_W-1:WORD_W];
    as_b   = dvs;
    as_sub = do_sub;
    if (state == ST_FIX)
    begin
      // restore only once, after the last step, never between steps
      as_a   = rem_r;
      as_b   = dvs_mag;
      as_sub = 1'b0;
    end
    // the new bit is set exactly when signs agree after the operation
    q_bit = (as_y[REM_W-1] == dvs[REM_W-1]);
    // a negative divisor inverts the sense of every recorded bit
    q_mag = dvs[REM_W-1] ? ~lo : lo;
    r_mag = rem_r[REM_W-1] ? as_y : rem_r;
    q_neg = dvd_neg ^ dvs[REM_W-1];
  end

  // ---------------------------------------------------------------------
  // next-state and next-output computation
  // ---------------------------------------------------------------------
  always_comb
  begin
    next_state      = state;
    next_cnt        = cnt;
    next_dvd        = dvd;
    next_dvd_neg    = dvd_neg;
    next_dvs        = dvs;
    next_dvs_mag    = dvs_mag;
    next_rem_r      = rem_r;
    next_lo         = lo;
    next_div_busy   = div_busy_o;
    next_div_done   = 1'b0;
    next_quotient   = quotient_o;
    next_remainder  = remainder_o;
    next_overflow   = overflow_o;
    next_div_zero   = div_zero_o;
    next_shift_done = shift_start_i;
    next_shift_word = shift_word_o;
    next_shift_lost = shift_lost_o;

    // user shift is independent of the divider and answers next cycle
    if (shift_start_i)
    begin
      next_shift_word = usr_sh;
      next_shift_lost = usr_lost;
    end

    case (state)
      ST_IDLE:
      begin
        if (div_start_i)
        begin
          next_dvd      = dividend_i;
          next_dvd_neg  = dividend_i[DVD_W-1];
          next_dvs      = {divisor_i[SIGN_BIT], divisor_i};
          next_dvs_mag  = divisor_i[SIGN_BIT]
                          ? REM_ZERO - {1'b1, divisor_i}
                          : {1'b0, divisor_i};
          next_cnt      = STEP_COUNT;
          next_div_busy = 1'b1;
          next_overflow = 1'b0;
          next_div_zero = 1'b0;
          next_state    = ST_PREP;
        end
      end

      ST_PREP:
      begin
        // complement a negative dividend; a zero divisor ends at once
        if (dvs == REM_ZERO)
        begin
          next_div_zero = 1'b1;
          next_overflow = 1'b1;
          next_div_busy = 1'b0;
          next_div_done = 1'b1;
          next_state    = ST_IDLE;
        end
        else
        begin
          if (dvd_neg)
          begin
            next_dvd = DVD_ZERO - dvd;
          end
          next_state = ST_CHECK;
        end
      end

      ST_CHECK:
      begin
        // most negative dividend, or a high half not below the divisor,
        // means the quotient needs more than one word
        if (dvd[DVD_W-1] || ({1'b0, dvd[DVD_W-1:WORD_W]} >= dvs_mag))
        begin
          next_overflow = 1'b1;
          next_div_busy = 1'b0;
          next_div_done = 1'b1;
          next_state    = ST_IDLE;
        end
        else
        begin
          next_rem_r = {1'b0, dvd[DVD_W-1:WORD_W]};
          next_lo    = dvd[WORD_W-1:0];
          next_state = ST_STEP;
        end
      end

      ST_STEP:
      begin
        // shift, then add or subtract the divisor: each step weighs the
        // divisor by the next smaller power of two against the dividend
        next_rem_r = as_y;
        next_lo    = {pair_sh[WORD_W-1:1], q_bit};
        next_cnt   = cnt - STEP_LAST;
        if (cnt == STEP_LAST)
        begin
          next_state = ST_FIX;
        end
      end

      ST_FIX:
      begin
        next_div_busy = 1'b0;
        next_div_done = 1'b1;
        next_cnt      = CNT_RESET;
        next_state    = ST_IDLE;
        // signed result must fit one word rather than be truncated
        if ((!q_neg && q_mag[SIGN_BIT]) || (q_neg && (q_mag > Q_NEG_MAX)))
        begin
          next_overflow = 1'b1;
        end
        else
        begin
          next_quotient  = q_neg ? WORD_ZERO - q_mag : q_mag;
          next_remainder = dvd_neg ? WORD_ZERO - r_mag[WORD_W-1:0]
                                   : r_mag[WORD_W-1:0];
        end
      end

      default:
      begin
        next_state    = ST_IDLE;
        next_div_busy = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // registers only
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state        <= ST_IDLE;
      cnt          <= CNT_RESET;
      dvd          <= DVD_ZERO;
      dvd_neg      <= 1'b0;
      dvs          <= REM_ZERO;
      dvs_mag      <= REM_ZERO;
      rem_r        <= REM_ZERO;
      lo           <= WORD_ZERO;
      div_busy_o   <= 1'b0;
      div_done_o   <= 1'b0;
      quotient_o   <= WORD_ZERO;
      remainder_o  <= WORD_ZERO;
      overflow_o   <= 1'b0;
      div_zero_o   <= 1'b0;
      shift_done_o <= 1'b0;
      shift_word_o <= WORD_ZERO;
      shift_lost_o <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      cnt          <= next_cnt;
      dvd          <= next_dvd;
      dvd_neg      <= next_dvd_neg;
      dvs          <= next_dvs;
      dvs_mag      <= next_dvs_mag;
      rem_r        <= next_rem_r;
      lo           <= next_lo;
      div_busy_o   <= next_div_busy;
      div_done_o   <= next_div_done;
      quotient_o   <= next_quotient;
      remainder_o  <= next_remainder;
      overflow_o   <= next_overflow;
      div_zero_o   <= next_div_zero;
      shift_done_o <= next_shift_done;
      shift_word_o <= next_shift_word;
      shift_lost_o <= next_shift_lost;
    end
  end

endmodule // divshift

// *** testbench/divshift_properties.sv ***
// assertion checker for the divide and shift block
`timescale 1ns/10ps
module divshift_properties
(
  // clock and reset
  input wire logic                            clk_i,
  input wire logic                            rst_n_i,
  // divide group
  input wire logic                            div_start_i,
  input wire logic [divshift_pkg::DVD_W-1:0]  dividend_i,
  input wire logic [divshift_pkg::WORD_W-1:0] divisor_i,
  input wire logic                            div_busy_o,
  input wire logic                            div_done_o,
  input wire logic [divshift_pkg::WORD_W-1:0] quotient_o,
  input wire logic [divshift_pkg::WORD_W-1:0] remainder_o,
  input wire logic                            overflow_o,
  input wire logic                            div_zero_o,
  // shift group
  input wire logic                            shift_start_i,
  input wire logic                            shift_left_i,
  input wire logic                            shift_fill_i,
  input wire logic [divshift_pkg::WORD_W-1:0] shift_word_i,
  input wire logic                            shift_done_o,
  input wire logic [divshift_pkg::WORD_W-1:0] shift_word_o,
  input wire logic                            shift_lost_o
);
  import divshift_pkg::*;
  logic [DVD_W-1:0]  mag;
  logic [WORD_W-1:0] dmag;
  logic              take;
  logic              norm;
  // a start that passes the precheck runs the full step sequence
  assign mag  = dividend_i[DVD_W-1] ? -dividend_i : dividend_i;
  assign dmag = divisor_i[SIGN_BIT] ? -divisor_i : divisor_i;
  assign take = div_start_i && !div_busy_o;
  assign norm = take && divisor_i != WORD_ZERO
                && dividend_i != 32'h80000000 && mag[31:16] < dmag;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ------------------------------
  // divide sequencing
  // ------------------------------
  AST_DIV_STEPS: assert property (norm |=> !div_done_o [*8] ##12 div_done_o)
    else $error("divide did not finish in its step count");
  AST_DIV_ZERO: assert property (take && divisor_i == WORD_ZERO |=> ##1
    div_done_o && div_zero_o && overflow_o)
    else $error("zero divisor not flagged");
  AST_DIV_TAKE: assert property (take |=> div_busy_o && !overflow_o
    && !div_zero_o)
    else $error("accepted start did not clear flags");
  AST_DONE_PULSE: assert property (div_done_o |=> !div_done_o)
    else $error("done longer than one cycle");
  AST_BUSY_END: assert property ($fell(div_busy_o) |-> div_done_o)
    else $error("busy fell without done");
  AST_OVF_HOLD: assert property (div_done_o && overflow_o |->
    $stable(quotient_o) && $stable(remainder_o))
    else $error("overflow changed the results");
  // ------------------------------
  // single shift
  // ------------------------------
  AST_SHIFT_DONE: assert property (1'b1 |=> shift_done_o == $past(shift_start_i))
    else $error("shift done not one cycle after start");
  AST_SHIFT_LEFT: assert property (shift_start_i && shift_left_i |=>
    shift_word_o == {$past(shift_word_i[14:0]), FILL_LEFT}
    && shift_lost_o == $past(shift_word_i[15]))
    else $error("left shift wrong");
  AST_SHIFT_RIGHT: assert property (shift_start_i && !shift_left_i |=>
    shift_word_o == {$past(shift_fill_i), $past(shift_word_i[15:1])}
    && shift_lost_o == $past(shift_word_i[0]))
    else $error("right shift wrong");
endmodule // divshift_properties

bind divshift divshift_properties chk_u (.clk_i, .rst_n_i, .div_start_i,
  .dividend_i, .divisor_i, .div_busy_o, .div_done_o, .quotient_o,
  .remainder_o, .overflow_o, .div_zero_o, .shift_start_i, .shift_left_i,
  .shift_fill_i, .shift_word_i, .shift_done_o, .shift_word_o,
  .shift_lost_o);

// *** testbench/host_model.sv ***
// host datapath model that issues divide requests
`timescale 1ns/10ps
module host_model
(
  // clock and completion
  input  wire logic                            clk_i,
  input  wire logic                            div_done_i,
  // divide request
  output      logic                            div_start_o,
  output      logic [divshift_pkg::DVD_W-1:0]  dividend_o,
  output      logic [divshift_pkg::WORD_W-1:0] divisor_o
);
  import divshift_pkg::*;
  // idle request lines
  initial
  begin
    div_start_o = 1'b0;
    dividend_o  = DVD_ZERO;
    divisor_o   = WORD_ZERO;
  end
  // call at a falling edge; returns at the falling edge of the done cycle, one edge
  // later for a zero divisor, so a following call starts back to back; operands invert once taken
  // so that a stale value can never pass for a held one; lat counts the
  // taking edge as the first cycle, so a normal divide reports 20
  task automatic divide(input logic [DVD_W-1:0] dvd,
                        input logic [WORD_W-1:0] dvs,
                        input logic junk, output int lat);
    int n;
    begin
      div_start_o = 1'b1;
      dividend_o  = dvd;
      divisor_o   = dvs;
      @(negedge clk_i);
      div_start_o = junk;     // second start while busy: must be ignored
      dividend_o  = ~dvd;
      divisor_o   = ~dvs;
      @(negedge clk_i);
      div_start_o = 1'b0;
      n = 2;
      while (div_done_i !== 1'b1 && n < 40)
      begin
        @(negedge clk_i);
        n++;
      end
      lat = n;
      // a zero divisor answers on the very edge that start was dropped:
      // let one edge pass so the next call never raises start again in
      // the same time step that lowered it
      if (n == 2)
        @(negedge clk_i);
    end
  endtask
endmodule // host_model

// *** testbench/test_divshift.sv ***
// self-checking testbench for the divide and shift block
`timescale 1ns/10ps
module test_divshift;
  import divshift_pkg::*;
  logic              clk_i, rst_n_i, div_start_i, div_busy_o, div_done_o;
  logic              overflow_o, div_zero_o, shift_start_i, shift_left_i;
  logic              shift_fill_i, shift_done_o, shift_lost_o;
  logic [DVD_W-1:0]  dividend_i;
  logic [WORD_W-1:0] divisor_i, quotient_o, remainder_o, q_prev, r_prev;
  logic [WORD_W-1:0] shift_word_i, shift_word_o;
  int                fail_count = 0;
  int                cmp_count = 0;
  int                cycles = 0;

  divshift dut_u (.clk_i, .rst_n_i, .div_start_i, .dividend_i, .divisor_i,
    .div_busy_o, .div_done_o, .quotient_o, .remainder_o, .overflow_o,
    .div_zero_o, .shift_start_i, .shift_left_i, .shift_fill_i,
    .shift_word_i, .shift_done_o, .shift_word_o, .shift_lost_o);
  host_model host_u (.clk_i, .div_done_i(div_done_o),
    .div_start_o(div_start_i), .dividend_o(dividend_i),
    .divisor_o(divisor_i));

  // 25 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // hang guard well above the few hundred cycles the tests need
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      end_sim();
    end
  end
  // ------------------------------
  // shared helpers
  // ------------------------------
  task automatic check(input logic ok, input string what);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one divide, expected value from signed arithmetic
  task automatic div_case(input logic [31:0] dvd, input logic [15:0] dvs,
                          input logic junk);
    longint a, b, q, r;
    logic   ovf;
    int     lat;
    begin
      a = longint'($signed(dvd));
      b = longint'($signed(dvs));
      q = (b != 0) ? a / b : 0;
      r = (b != 0) ? a % b : 0;
      ovf = (b == 0) || q > 32767 || q < -32768;
      host_u.divide(dvd, dvs, junk, lat);
      check(overflow_o === ovf, "overflow flag");
      check(div_zero_o === (b == 0), "zero divisor flag");
      if (!ovf)
      begin
        q_prev = 16'(q);
        r_prev = 16'(r);
        check(lat == 20, "divide latency");
      end
      check(quotient_o === q_prev, "quotient");
      check(remainder_o === r_prev, "remainder");
      if (b == 0)
        check(lat == 2, "zero divisor latency");
    end
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  // back-to-back divides over every sign pairing and the range edges
  task automatic t_div;
    logic [31:0] dv[13] = '{32'h11, 32'hffffffef, 32'h11, 32'hffffffef,
      32'h0, 32'h3fff8000, 32'h3fff7fff, 32'hffff0000, 32'h10000,
      32'h80000000, 32'h12345678, 32'hffff8000, 32'hffff};
    logic [15:0] ds[13] = '{16'h5, 16'h5, 16'hfffb, 16'hfffb, 16'h7,
      16'h7fff, 16'h7fff, 16'h2, 16'h1, 16'h3, 16'h0, 16'hffff, 16'h8000};
    begin
      for (int i = 0; i < 13; i++)
        div_case(dv[i], ds[i], i % 3 == 1);
      $display("test divide done");
    end
  endtask
  // one shift per cycle, both directions and both fills
  task automatic t_shift;
    logic [15:0] w[4] = '{16'h8001, 16'h0001, 16'hffff, 16'h5aa5};
    logic [15:0] e;
    begin
      for (int i = 0; i < 16; i++)
      begin
        shift_start_i = 1'b1;
        shift_word_i  = w[i/4];
        shift_left_i  = i[0];
        shift_fill_i  = i[1];
        e = i[0] ? {w[i/4][14:0], 1'b0} : {i[1], w[i/4][15:1]};
        @(negedge clk_i);
        check(shift_done_o === 1'b1, "shift done");
        check(shift_word_o === e, "shifted word");
        check(shift_lost_o === (i[0] ? w[i/4][15] : w[i/4][0]), "lost");
      end
      shift_start_i = 1'b0;
      shift_word_i  = ~shift_word_i;
      @(negedge clk_i);
      check(shift_done_o === 1'b0, "shift idle");
      $display("test shift done");
    end
  endtask
  // reset after the runs end clears every result, then a divide runs again
  task automatic t_reset;
    rst_n_i = 1'b0;
    #1;
    check({div_busy_o, div_done_o, overflow_o, div_zero_o, shift_done_o,
      shift_lost_o, quotient_o, remainder_o, shift_word_o} === '0,
      "reset values");
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    q_prev = WORD_ZERO;
    r_prev = WORD_ZERO;
    repeat (2) @(negedge clk_i);
    div_case(32'hffffffef, 16'h5, 1'b0);
    $display("test reset done");
  endtask

  // main sequence: divides and shifts run side by side
  initial
  begin
    rst_n_i       = 1'b0;
    shift_start_i = 1'b0;
    shift_left_i  = 1'b0;
    shift_fill_i  = 1'b0;
    shift_word_i  = WORD_ZERO;
    q_prev        = WORD_ZERO;
    r_prev        = WORD_ZERO;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    fork
      t_shift();
      t_div();
    join
    t_reset();
    end_sim();
  end
endmodule // test_divshift
